// ---- rtl/ccc_average.sv ----
// Sequential moving-average step: (2^k * old + x) / (2^k + 1), rounded toward zero
`timescale 1ns/1ps
module ccc_average #(
	parameter int NUM_W = 24,
	parameter int DEN_W = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Request
	input wire logic start_in,
	input wire logic signed [15:0] old_avg_in,
	input wire logic signed [16:0] sample_in,
	input wire logic [2:0] weight_in,
	// Result
	output logic busy_out,
	output logic done_out,
	output logic signed [15:0] avg_out
);
	import ccc_pkg::*;

	ccc_av_state_t state_q;
	logic [NUM_W-1:0] quo_q;
	logic [DEN_W-1:0] rem_q;
	logic [DEN_W-1:0] den_q;
	logic [$clog2(NUM_W)-1:0] cnt_q;
	logic neg_q;
	logic signed [NUM_W-1:0] num;
	logic [DEN_W:0] trial;

	// Weight up to 2^7 keeps the numerator inside NUM_W bits
	assign num = (NUM_W'(old_avg_in) <<< weight_in) + NUM_W'(sample_in);
	assign trial = {rem_q, quo_q[NUM_W-1]};

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= CCC_AV_IDLE;
			quo_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			neg_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				CCC_AV_IDLE:
				begin
					if (start_in)
					begin
						neg_q <= num[NUM_W-1];
						quo_q <= num[NUM_W-1] ? NUM_W'(-num) : NUM_W'(num);
						rem_q <= '0;
						den_q <= DEN_W'((1 << weight_in) + 1);
						cnt_q <= ($clog2(NUM_W))'(NUM_W - 1);
						state_q <= CCC_AV_RUN;
					end
				end
				CCC_AV_RUN:
				begin
					if (trial >= {1'b0, den_q})
					begin
						rem_q <= DEN_W'(trial - {1'b0, den_q});
						quo_q <= {quo_q[NUM_W-2:0], 1'b1};
					end
					else
					begin
						rem_q <= trial[DEN_W-1:0];
						quo_q <= {quo_q[NUM_W-2:0], 1'b0};
					end
					if (cnt_q == '0)
						state_q <= CCC_AV_DONE;
					else
						cnt_q <= cnt_q - 1'b1;
				end
				CCC_AV_DONE:
					state_q <= CCC_AV_IDLE;
			endcase
		end
	end

	assign busy_out = (state_q != CCC_AV_IDLE);
	assign done_out = (state_q == CCC_AV_DONE);
	assign avg_out = neg_q ? 16'(-quo_q) : quo_q[15:0];
endmodule

// ---- rtl/ccc_pkg.sv ----
// Shared constants, register map and carrier types of the coulomb counter control block
package ccc_pkg;
	// Register indices as printed; the byte address is four times the index
	localparam logic [31:0] CCC_IDX_CTRL = 32'h50001B40;
	localparam logic [31:0] CCC_IDX_EXTRA = 32'h50001B46;
	localparam logic [31:0] CCC_IDX_CNT_LOW = 32'h50001B48;
	localparam logic [31:0] CCC_IDX_CNT_MID = 32'h50001B4A;
	localparam logic [31:0] CCC_IDX_CNT_HIGH = 32'h50001B4C;
	localparam logic [31:0] CCC_IDX_AVERAGE = 32'h50001B50;
	localparam logic [31:0] CCC_IDX_FLAGS = 32'h50001B52;
	localparam logic [31:0] CCC_IDX_OVERRIDE = 32'h50001B54;
	localparam logic [31:0] CCC_IDX_OBSERVE = 32'h50001B56;
	localparam logic [31:0] CCC_IDX_IRQ_STAT = 32'h50001B58;
	localparam logic [31:0] CCC_IDX_IRQ_MASK = 32'h50001B5A;
	// Reset values
	localparam logic [15:0] CCC_RST_ZERO = 16'h0000;
	localparam logic [15:0] CCC_RST_CTRL = 16'h7000;
	// Control register fields
	localparam int CCC_CTRL_EN_BIT = 0;
	localparam int CCC_CTRL_RSTCH_BIT = 1;
	localparam int CCC_CTRL_RSTAVG_BIT = 2;
	localparam int CCC_CTRL_MAW_LSB = 12;
	// Override register fields
	localparam int CCC_OVR_DAC_EN_BIT = 15;
	localparam int CCC_OVR_SEG_EN_BIT = 14;
	localparam int CCC_OVR_SEG_LSB = 11;
	localparam int CCC_OVR_RDIV_BIT = 10;
	localparam int CCC_OVR_SIGN_BIT = 9;
	localparam int CCC_OVR_VAL_LSB = 0;
	// Flag and interrupt bit positions (same layout in flags, irq status and mask)
	localparam int CCC_FLAG_OVL_BIT = 0;
	localparam int CCC_FLAG_LOCK_BIT = 1;
	// Counter slicing
	localparam int CCC_COUNT_W = 40;
	localparam int CCC_MID_LSB = 16;
	localparam int CCC_HIGH_LSB = 32;
	// Fixed point and period counts
	localparam int CCC_FRAC_BITS = 6;
	localparam logic [1:0] CCC_SAFE_PERIODS = 2'd2;
	localparam logic [1:0] CCC_OVL_PERIODS = 2'd3;
	localparam int CCC_COARSE_DROP = 3;
	localparam logic [8:0] CCC_DAC_FULL_FINE = 9'h1FF;
	localparam logic [5:0] CCC_DAC_FULL_COARSE = 6'h3F;

	typedef struct packed {
		logic ctrl_event;
		logic [3:0] ctrl_state;
		logic rising;
		logic positive;
		logic low_limit_comparator_out;
		logic high_limit_comparator_out;
	} ccc_comp_t;

	typedef struct packed {
		logic sign;
		logic [8:0] external_dac_value;
	} ccc_dac_t;

	typedef enum logic [1:0] {
		CCC_AV_IDLE = 2'b00,
		CCC_AV_RUN = 2'b01,
		CCC_AV_DONE = 2'b11
	} ccc_av_state_t;
endpackage

// ---- rtl/ccc_top.sv ----
// Coulomb counter control: charge accumulation, averaging, integrator flags and DAC override
`timescale 1ns/1ps
module ccc_top #(
	parameter int DELTA_C = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Avalon-MM slave
	input wire logic [31:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Analog converter side
	input wire logic sample_strobe_in,
	input wire logic signed [6:0] charge_sample_in,
	input wire ccc_pkg::ccc_comp_t comp_in,
	input wire ccc_pkg::ccc_dac_t ctrl_dac_in,
	input wire logic [2:0] ctrl_segment_in,
	output ccc_pkg::ccc_dac_t dac_out,
	output logic resistor_divider_select_out,
	output logic [2:0] segment_cycle_number_out,
	output logic analog_enable_out,
	// Interrupt
	output logic irq_out
);
	import ccc_pkg::*;

	localparam logic [6:0] SAFE_LIM = 7'(2 * DELTA_C);

	logic [15:0] ctrl_q;
	logic [15:0] extra_charge_q;
	logic [15:0] override_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic signed [CCC_COUNT_W-1:0] count_q;
	logic signed [15:0] avg_q;
	logic integrator_lock_flag_q;
	logic integrator_overload_flag_q;
	logic [1:0] safe_cnt_q;
	logic [1:0] ovl_cnt_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q;
	ccc_dac_t dac_q;
	logic rdiv_q;
	logic [2:0] seg_q;
	logic rst_charge_q;
	logic rst_avg_q;

	logic wr_take;
	logic signed [CCC_COUNT_W-1:0] delta;
	logic [6:0] sample_mag;
	logic safe;
	logic at_limit;
	logic lock_set;
	logic ovl_set;
	logic dac_full;
	logic av_done;
	logic signed [15:0] av_result;
	ccc_dac_t dac_d;
	logic [15:0] rd_d;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Bus: one wait cycle, then the write lands on the edge that sees waitrequest low
	assign wr_take = avs_write_in && !wait_q;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			wait_q <= 1'b1;
		else if ((avs_read_in || avs_write_in) && wait_q)
			wait_q <= 1'b0;
		else
			wait_q <= 1'b1;
	end

	always_comb
	begin
		rd_d = CCC_RST_ZERO;
		unique case (avs_address_in)
			CCC_IDX_CTRL: rd_d = ctrl_q;
			CCC_IDX_EXTRA: rd_d = extra_charge_q;
			CCC_IDX_CNT_LOW: rd_d = count_q[CCC_MID_LSB-1:0];
			CCC_IDX_CNT_MID: rd_d = count_q[CCC_HIGH_LSB-1:CCC_MID_LSB];
			CCC_IDX_CNT_HIGH: rd_d = {8'h00, count_q[CCC_COUNT_W-1:CCC_HIGH_LSB]};
			CCC_IDX_AVERAGE: rd_d = avg_q;
			CCC_IDX_FLAGS: rd_d = {14'h0000, integrator_lock_flag_q, integrator_overload_flag_q};
			CCC_IDX_OVERRIDE: rd_d = override_q;
			CCC_IDX_OBSERVE: rd_d = {7'h00, comp_in};
			CCC_IDX_IRQ_STAT: rd_d = {14'h0000, irq_stat_q};
			CCC_IDX_IRQ_MASK: rd_d = {14'h0000, irq_mask_q};
			default: rd_d = CCC_RST_ZERO;
		endcase
	end

	// Read data is prepared during the wait cycle; reading never touches state
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			rdata_q <= 32'h00000000;
		else if (avs_read_in && wait_q)
			rdata_q <= {16'h0000, rd_d};
	end

	// Software registers; reset pulses in the control word clear themselves
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			ctrl_q <= CCC_RST_CTRL;
			extra_charge_q <= CCC_RST_ZERO;
			override_q <= CCC_RST_ZERO;
			irq_mask_q <= 2'b00;
			rst_charge_q <= 1'b0;
			rst_avg_q <= 1'b0;
		end
		else
		begin
			rst_charge_q <= 1'b0;
			rst_avg_q <= 1'b0;
			if (wr_take && avs_address_in == CCC_IDX_CTRL)
			begin
				ctrl_q <= merge16(ctrl_q, avs_writedata_in, avs_byteenable_in);
				rst_charge_q <= avs_byteenable_in[0] && avs_writedata_in[CCC_CTRL_RSTCH_BIT];
				rst_avg_q <= avs_byteenable_in[0] && avs_writedata_in[CCC_CTRL_RSTAVG_BIT];
			end
			else
			begin
				ctrl_q[CCC_CTRL_RSTCH_BIT] <= 1'b0;
				ctrl_q[CCC_CTRL_RSTAVG_BIT] <= 1'b0;
			end
			if (wr_take && avs_address_in == CCC_IDX_EXTRA)
				extra_charge_q <= merge16(extra_charge_q, avs_writedata_in, avs_byteenable_in);
			if (wr_take && avs_address_in == CCC_IDX_OVERRIDE)
				override_q <= merge16(override_q, avs_writedata_in, avs_byteenable_in);
			if (wr_take && avs_address_in == CCC_IDX_IRQ_MASK && avs_byteenable_in[0])
				irq_mask_q <= avs_writedata_in[1:0];
		end
	end

	// Per-period charge: scaled converter sample when enabled, plus the extra charge
	// With the analog part off only the extra charge counts, allowing manual updates
	assign delta = (ctrl_q[CCC_CTRL_EN_BIT] ? (CCC_COUNT_W'(charge_sample_in) <<< CCC_FRAC_BITS) : '0)
		+ CCC_COUNT_W'($signed(extra_charge_q));

	// 40 bits in 1/64 units hold 2^27 periods of 6-bit full scale with sign to spare
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			count_q <= '0;
		else if (rst_charge_q)
			count_q <= '0;
		else if (sample_strobe_in)
			count_q <= count_q + delta;
	end

	ccc_average #(
		.NUM_W(24),
		.DEN_W(8)
	) u_average (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.start_in(sample_strobe_in),
		.old_avg_in(avg_q),
		.sample_in(delta[16:0]),
		.weight_in(ctrl_q[CCC_CTRL_MAW_LSB +: 3]),
		.busy_out(),
		.done_out(av_done),
		.avg_out(av_result)
	);

	// A reset request wins over a finishing average step
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			avg_q <= '0;
		else if (rst_avg_q)
			avg_q <= count_q[15:0];
		else if (av_done)
			avg_q <= av_result;
	end

	// Integrator limit supervision, evaluated once per sampling period
	assign sample_mag = charge_sample_in[6] ? 7'(-charge_sample_in) : 7'(charge_sample_in);
	assign safe = sample_mag < SAFE_LIM;
	assign at_limit = comp_in.high_limit_comparator_out || comp_in.low_limit_comparator_out;
	assign lock_set = sample_strobe_in && ctrl_q[CCC_CTRL_EN_BIT] && at_limit;
	assign dac_full = rdiv_q ? (dac_q.external_dac_value == CCC_DAC_FULL_FINE)
		: (dac_q.external_dac_value[8:CCC_COARSE_DROP] == CCC_DAC_FULL_COARSE);
	assign ovl_set = sample_strobe_in && at_limit && dac_full && ovl_cnt_q == CCC_OVL_PERIODS
		&& !integrator_overload_flag_q;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			integrator_lock_flag_q <= 1'b0;
			safe_cnt_q <= 2'd0;
		end
		else if (lock_set)
		begin
			integrator_lock_flag_q <= 1'b1;
			safe_cnt_q <= 2'd0;
		end
		else if (sample_strobe_in)
		begin
			if (!safe)
				safe_cnt_q <= 2'd0;
			else if (safe_cnt_q == CCC_SAFE_PERIODS)
				integrator_lock_flag_q <= 1'b0;
			else
				safe_cnt_q <= safe_cnt_q + 2'd1;
		end
	end

	// The counter saturates at three; the fourth limit period raises overload
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			integrator_overload_flag_q <= 1'b0;
			ovl_cnt_q <= 2'd0;
		end
		else if (sample_strobe_in)
		begin
			if (at_limit && dac_full)
			begin
				if (ovl_cnt_q == CCC_OVL_PERIODS)
					integrator_overload_flag_q <= 1'b1;
				else
					ovl_cnt_q <= ovl_cnt_q + 2'd1;
			end
			else
			begin
				ovl_cnt_q <= 2'd0;
				integrator_overload_flag_q <= 1'b0;
			end
		end
	end

	// Sticky interrupt status; a new event in the clearing cycle survives
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			irq_stat_q <= 2'b00;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if ((i == CCC_FLAG_LOCK_BIT && lock_set && !integrator_lock_flag_q)
					|| (i == CCC_FLAG_OVL_BIT && ovl_set))
					irq_stat_q[i] <= 1'b1;
				else if (wr_take && avs_address_in == CCC_IDX_IRQ_STAT && avs_byteenable_in[0]
					&& avs_writedata_in[i])
					irq_stat_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	// DAC command: software fields replace the controller, coarse mode drops the divider bits
	always_comb
	begin
		dac_d = ctrl_dac_in;
		if (override_q[CCC_OVR_DAC_EN_BIT])
		begin
			dac_d.sign = override_q[CCC_OVR_SIGN_BIT];
			dac_d.external_dac_value = override_q[CCC_OVR_VAL_LSB +: 9];
		end
		if (!override_q[CCC_OVR_RDIV_BIT])
			dac_d.external_dac_value[CCC_COARSE_DROP-1:0] = 3'b000;
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			dac_q <= '0;
			rdiv_q <= 1'b0;
			seg_q <= 3'd0;
		end
		else
		begin
			dac_q <= dac_d;
			rdiv_q <= override_q[CCC_OVR_RDIV_BIT];
			seg_q <= override_q[CCC_OVR_SEG_EN_BIT] ? override_q[CCC_OVR_SEG_LSB +: 3] : ctrl_segment_in;
		end
	end

	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out = rdata_q;
	assign dac_out = dac_q;
	assign resistor_divider_select_out = rdiv_q;
	assign segment_cycle_number_out = seg_q;
	assign analog_enable_out = ctrl_q[CCC_CTRL_EN_BIT];
	assign irq_out = irq_q;

	// Checks
	count_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		sample_strobe_in && !rst_charge_q |=> count_q == $past(count_q) + $past(delta))
		else $error("charge counter did not add the period charge");
	count_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rst_charge_q |=> count_q == '0)
		else $error("charge reset did not clear the counter");
	extra_only_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!ctrl_q[CCC_CTRL_EN_BIT] |-> delta == CCC_COUNT_W'($signed(extra_charge_q)))
		else $error("disabled converter still contributed charge");
	lock_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		lock_set |=> integrator_lock_flag_q ##1 integrator_lock_flag_q)
		else $error("lock flag not held after a limit hit");
	lock_release_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$fell(integrator_lock_flag_q) |-> $past(safe_cnt_q) == CCC_SAFE_PERIODS && $past(safe))
		else $error("lock flag cleared too early");
	overload_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(integrator_overload_flag_q) |-> $past(ovl_cnt_q) == CCC_OVL_PERIODS && $past(dac_full))
		else $error("overload flag rose without four full-scale limit periods");
	dac_override_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		override_q[CCC_OVR_DAC_EN_BIT] && override_q[CCC_OVR_RDIV_BIT]
		|=> dac_out == $past(override_q[CCC_OVR_VAL_LSB +: 10]))
		else $error("DAC override fields not driven");
	dac_coarse_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!override_q[CCC_OVR_RDIV_BIT] |=> dac_out.external_dac_value[CCC_COARSE_DROP-1:0] == 3'b000)
		else $error("coarse DAC mode kept divider bits");
	segment_override_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		override_q[CCC_OVR_SEG_EN_BIT] |=> segment_cycle_number_out == $past(override_q[CCC_OVR_SEG_LSB +: 3]))
		else $error("segment override not applied");
	avg_reset_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rst_avg_q |=> avg_q == $past(count_q[15:0]))
		else $error("average reset did not load the counter");
	bus_answer_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus request not answered within one cycle");
	irq_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ovl_set || (lock_set && !integrator_lock_flag_q)) && irq_mask_q == 2'b11 |=> ##1 irq_out)
		else $error("unmasked event did not raise the interrupt");

	lock_cycle_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		integrator_lock_flag_q ##1 !integrator_lock_flag_q);
	overload_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(integrator_overload_flag_q));
	average_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) av_done && avg_q != av_result);
	override_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		override_q[CCC_OVR_DAC_EN_BIT] && override_q[CCC_OVR_SIGN_BIT]);
endmodule

// ---- verif/ccc_analog_model.sv ----
// Behavioural model of the analog integrator, comparators and internal DAC controller
`timescale 1ns/1ps
module ccc_analog_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Bench commands
	input wire logic go_in,
	input wire logic signed [6:0] sample_in,
	input wire ccc_pkg::ccc_comp_t comp_in,
	// Towards the block
	output logic strobe_out,
	output logic signed [6:0] charge_out,
	output ccc_pkg::ccc_comp_t comp_out,
	output logic [2:0] segment_out
);
	import ccc_pkg::*;

	logic signed [6:0] last_q;
	// Strobes keep coming with the analog side off, so manual updates still land
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			strobe_out <= 1'h0;
			last_q <= 7'h00;
			segment_out <= 3'h0;
		end
		else
		begin
			strobe_out <= go_in;
			if (go_in)
				last_q <= sample_in;
			if (strobe_out)
				segment_out <= segment_out + 3'h1;
		end
	end
	// Charge is only valid on the strobe; elsewhere show a changing value
	assign charge_out = strobe_out ? last_q : ~last_q;
	assign comp_out = comp_in;
endmodule

// ---- verif/tb_ccc_top.sv ----
// Self-checking bench for the coulomb counter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb_ccc_top;
	import ccc_pkg::*;
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [31:0] rdata;
	logic wait_r;
	logic go = 1'h0;
	logic signed [6:0] smp = 7'h00;
	ccc_comp_t obs = '0;
	ccc_dac_t cdac = '0;
	logic strobe;
	logic signed [6:0] chg;
	ccc_comp_t comp;
	logic [2:0] seg;
	ccc_dac_t dac;
	logic rdiv;
	logic [2:0] segn;
	logic irq;
	logic aen;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 81969;
	logic [39:0] exp_cnt = 40'h0;
	logic signed [15:0] exp_avg = 16'h0000;
	logic [15:0] extra = 16'h0000;
	logic [15:0] ov;
	logic en = 1'h0;
	logic [2:0] k = 3'h7;
	logic [31:0] r;
	logic [31:0] idx [11] = '{CCC_IDX_EXTRA, CCC_IDX_CNT_LOW, CCC_IDX_CNT_MID, CCC_IDX_CNT_HIGH,
		CCC_IDX_AVERAGE, CCC_IDX_FLAGS, CCC_IDX_OVERRIDE, CCC_IDX_OBSERVE, CCC_IDX_IRQ_STAT,
		CCC_IDX_IRQ_MASK, 32'h50001B5E};

	initial forever #20 clk_in = ~clk_in;

	ccc_top i_ccc_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_r), .sample_strobe_in(strobe), .charge_sample_in(chg), .comp_in(comp),
		.ctrl_dac_in(cdac), .ctrl_segment_in(seg), .dac_out(dac), .resistor_divider_select_out(rdiv),
		.segment_cycle_number_out(segn), .analog_enable_out(aen), .irq_out(irq));
	ccc_analog_model i_ccc_analog_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .go_in(go),
		.sample_in(smp), .comp_in(obs), .strobe_out(strobe), .charge_out(chg), .comp_out(comp),
		.segment_out(seg));

	task automatic summarize;
		$display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			miscompares++;
			summarize();
		end
	end

	// Avalon transfer: held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= {16'h0000, d};
		rd <= !w;
		wr <= w;
		do @(posedge clk_in); while (wait_r !== 1'h0);
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge clk_in);
	endtask

	task automatic rchk(input string n, input logic [31:0] a, input logic [15:0] e);
		bus(1'h0, a, 16'h0000);
		`CHK(n, {16'h0000, e}, r)
	endtask

	task automatic ctrl(input logic [2:0] b);
		en = b[0];
		bus(1'h1, CCC_IDX_CTRL, {1'h0, k, 9'h000, b});
		if (b[1])
			exp_cnt = 40'h0;
		if (b[2])
			exp_avg = exp_cnt[15:0];
		repeat (3) @(posedge clk_in);
		`CHK("analog_enable", b[0], aen)
	endtask

	// One sampling period; expectations follow the accumulate and average rules
	task automatic period(input logic signed [6:0] s, input logic hi);
		longint dl;
		longint w;
		smp <= s;
		obs.high_limit_comparator_out <= hi;
		go <= 1'h1;
		@(posedge clk_in);
		go <= 1'h0;
		repeat (31) @(posedge clk_in);
		dl = (en ? longint'(s) * 64 : 0) + longint'($signed(extra));
		exp_cnt = exp_cnt + 40'(dl);
		w = longint'(1) << k;
		exp_avg = 16'((w * exp_avg + longint'($signed(dl[16:0]))) / (w + 1));
	endtask

	task automatic cnt_chk;
		rchk("count_low", CCC_IDX_CNT_LOW, exp_cnt[15:0]);
		rchk("count_mid", CCC_IDX_CNT_MID, exp_cnt[31:16]);
		rchk("count_high", CCC_IDX_CNT_HIGH, {8'h00, exp_cnt[39:32]});
		rchk("average", CCC_IDX_AVERAGE, exp_avg);
	endtask

	function automatic ccc_dac_t dac_f(input logic [15:0] o, input ccc_dac_t c);
		ccc_dac_t x;
		x = o[15] ? ccc_dac_t'(o[9:0]) : c;
		// Coarse mode drops the three divider bits
		if (!o[10])
			x.external_dac_value[2:0] = 3'h0;
		return x;
	endfunction

	initial
	begin
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'h1;
		@(posedge clk_in);
		rchk("control", CCC_IDX_CTRL, CCC_RST_CTRL);
		foreach (idx[i])
			rchk("reset_value", idx[i], 16'h0000);
		$display("test reset done");
		bus(1'h1, CCC_IDX_IRQ_MASK, 16'h0003);
		extra = 16'($random(seed) % 512);
		bus(1'h1, CCC_IDX_EXTRA, extra);
		rchk("extra", CCC_IDX_EXTRA, extra);
		repeat (3) period(7'($random(seed)), 1'h0);
		cnt_chk();
		$display("test manual update done");
		k = 3'($random(seed));
		ctrl(3'h1);
		repeat (6) period(7'($random(seed)), 1'h0);
		cnt_chk();
		ctrl(3'h3);
		period(-7'sd63, 1'h0);
		cnt_chk();
		ctrl(3'h5);
		rchk("average_reset", CCC_IDX_AVERAGE, exp_avg);
		$display("test accumulate done");
		period(7'sh00, 1'h1);
		rchk("lock_set", CCC_IDX_FLAGS, 16'h0002);
		`CHK("irq_lock", 1'h1, irq)
		rchk("irq_status", CCC_IDX_IRQ_STAT, 16'h0002);
		bus(1'h1, CCC_IDX_IRQ_STAT, 16'h0002);
		repeat (2) @(posedge clk_in);
		`CHK("irq_cleared", 1'h0, irq)
		period(7'sh00, 1'h0);
		period(7'sh00, 1'h0);
		period(7'sh02, 1'h0);
		period(7'sh00, 1'h0);
		period(7'sh00, 1'h0);
		rchk("lock_held", CCC_IDX_FLAGS, 16'h0002);
		period(7'sh00, 1'h0);
		rchk("lock_clear", CCC_IDX_FLAGS, 16'h0000);
		cnt_chk();
		$display("test lock done");
		bus(1'h1, CCC_IDX_IRQ_MASK, 16'h0000);
		bus(1'h1, CCC_IDX_OVERRIDE, 16'h85FF);
		repeat (3) period(7'sh00, 1'h1);
		rchk("ovl_wait", CCC_IDX_FLAGS, 16'h0002);
		period(7'sh00, 1'h1);
		rchk("ovl_set", CCC_IDX_FLAGS, 16'h0003);
		`CHK("irq_masked", 1'h0, irq)
		bus(1'h1, CCC_IDX_IRQ_MASK, 16'h0001);
		repeat (2) @(posedge clk_in);
		`CHK("irq_unmasked", 1'h1, irq)
		period(7'sh00, 1'h0);
		rchk("ovl_clear", CCC_IDX_FLAGS, 16'h0002);
		$display("test overload done");
		repeat (8)
		begin
			ov = 16'($random(seed));
			cdac <= ccc_dac_t'($random(seed));
			bus(1'h1, CCC_IDX_OVERRIDE, ov);
			repeat (2) @(posedge clk_in);
			`CHK("dac", dac_f(ov, cdac), dac)
			`CHK("divider", ov[10], rdiv)
			`CHK("segment", ov[14] ? ov[13:11] : seg, segn)
			rchk("override", CCC_IDX_OVERRIDE, ov);
		end
		$display("test override done");
		repeat (4)
		begin
			obs <= ccc_comp_t'($random(seed));
			repeat (2) @(posedge clk_in);
			rchk("observe", CCC_IDX_OBSERVE, {7'h00, obs});
		end
		$display("test observe done");
		summarize();
	end
endmodule
